// ===== common/acs_pkg.sv
// constants shared by the converter sleep and auto-trigger control block
// assumes a single clock domain and a plain register port
package acs_pkg;

	localparam int ADDR_W   = 3;
	localparam int DATA_W   = 8;
	localparam int RES_W    = 10;
	localparam int N_TRIG   = 12;
	localparam int SEL_W    = 4;

	// register indices on the plain port
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL2 = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_RESH  = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_RESL  = 3'h4;

	// converter_control_zero fields
	localparam int BIT_EN = 0;
	localparam int BIT_GO = 1;
	localparam int BIT_RC = 2;
	localparam int BIT_IE = 3;

	// status fields
	localparam int BIT_DONE = 0;
	localparam int BIT_ON   = 1;
	localparam int BIT_BUSY = 2;

	// result split: high register holds the top bits in its low lanes
	localparam int RESL_W = 8;
	localparam int RESH_W = RES_W - RESL_W;

	// trigger_source_select codes; 0 selects nothing
	localparam logic [SEL_W-1:0] TRIG_NONE      = 4'h0;
	localparam logic [SEL_W-1:0] TRIG_CCP_ONE   = 4'h1;
	localparam logic [SEL_W-1:0] TRIG_CCP_TWO   = 4'h2;
	localparam logic [SEL_W-1:0] TRIG_T0_WRAP   = 4'h3;
	localparam logic [SEL_W-1:0] TRIG_T1_WRAP   = 4'h4;
	localparam logic [SEL_W-1:0] TRIG_T2_HIT    = 4'h5;
	localparam logic [SEL_W-1:0] TRIG_T4_HIT    = 4'h6;
	localparam logic [SEL_W-1:0] TRIG_T6_HIT    = 4'h7;
	localparam logic [SEL_W-1:0] TRIG_CMP_ONE   = 4'h8;
	localparam logic [SEL_W-1:0] TRIG_CMP_TWO   = 4'h9;
	localparam logic [SEL_W-1:0] TRIG_LC_ONE    = 4'hA;
	localparam logic [SEL_W-1:0] TRIG_LC_TWO    = 4'hB;
	localparam logic [SEL_W-1:0] TRIG_LC_THREE  = 4'hC;

	// timing: one instruction cycle is four system clocks
	localparam int INSTR_CLKS = 4;
	localparam int BIT_CLKS   = 2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DELAY,
		ST_CONV
	} acs_state_type;

endpackage : acs_pkg

// ===== rtl/acs_ctrl.sv
// converter control: sleep handling, auto-trigger, successive approximation
// assumes a comparator outside answers cmp_i for the trial code each cycle
`timescale 1ns/1ps
`default_nettype none

module acs_ctrl #(
	parameter int INSTR_CLKS_P = acs_pkg::INSTR_CLKS,
	parameter int BIT_CLKS_P   = acs_pkg::BIT_CLKS
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic [acs_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [acs_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [acs_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                       sleep_i,
	input  wire logic                       cmp_i,
	input  wire logic                       capture_compare_one_i,
	input  wire logic                       capture_compare_two_i,
	input  wire logic                       timer_zero_wrap_i,
	input  wire logic                       timer_one_wrap_i,
	input  wire logic                       timer_two_period_hit_i,
	input  wire logic                       timer_four_period_hit_i,
	input  wire logic                       timer_six_period_hit_i,
	input  wire logic                       comparator_one_synced_i,
	input  wire logic                       comparator_two_synced_i,
	input  wire logic                       logic_cell_one_output_i,
	input  wire logic                       logic_cell_two_output_i,
	input  wire logic                       logic_cell_three_output_i,
	output logic      [acs_pkg::RES_W-1:0]  trial_code_o,
	output logic                            hold_o,
	output logic                            converter_on_o,
	output logic                            wake_o
);
	import acs_pkg::*;

	localparam int ICW = $clog2(INSTR_CLKS_P + 1);
	localparam int BCW = $clog2(BIT_CLKS_P + 1);
	localparam int IXW = $clog2(RES_W);
	localparam logic [ICW-1:0] INSTR_LAST = ICW'(INSTR_CLKS_P - 1);
	localparam logic [BCW-1:0] BIT_LAST   = BCW'(BIT_CLKS_P - 1);
	localparam logic [IXW-1:0] IDX_TOP    = IXW'(RES_W - 1);

	acs_state_type            state;
	logic                     converter_enable;
	logic                     go;
	logic                     dedicated_rc_clock;
	logic                     int_enable;
	logic [SEL_W-1:0]         trigger_source_select;
	logic                     conversion_done_flag;
	logic                     power_off;
	logic [RES_W-1:0]         result;
	logic [RES_W-1:0]         code;
	logic [IXW-1:0]           idx;
	logic [ICW-1:0]           delay_cnt;
	logic [BCW-1:0]           bit_cnt;
	logic                     sleep_prev;
	logic                     trig_prev;
	logic [SEL_W-1:0]         sel_prev;
	logic [N_TRIG-1:0]        trig_vec;
	logic                     trig_lvl;
	logic                     trig_edge;
	logic                     sleep_rise;
	logic                     abort;
	logic                     bit_step;
	logic                     finish;
	logic                     sw_stop;
	logic                     wr_ctrl0;
	logic                     conv_on;
	logic [RES_W-1:0]         partial;
	logic [DATA_W-1:0]        next_rdata;

	assign wr_ctrl0 = wr_i && (addr_i == OFS_CTRL0);
	assign conv_on  = converter_enable && !power_off;

	// source order matches the select codes, code minus one is the index
	assign trig_vec = {logic_cell_three_output_i, logic_cell_two_output_i,
		logic_cell_one_output_i, comparator_two_synced_i,
		comparator_one_synced_i, timer_six_period_hit_i,
		timer_four_period_hit_i, timer_two_period_hit_i,
		timer_one_wrap_i, timer_zero_wrap_i,
		capture_compare_two_i, capture_compare_one_i};

	always_comb begin
		trig_lvl = 1'b0;
		if (trigger_source_select != TRIG_NONE &&
		    trigger_source_select <= TRIG_LC_THREE) begin
			trig_lvl = trig_vec[trigger_source_select - 4'h1];
		end
	end

	// a select change must not look like an edge
	assign trig_edge = trig_lvl && !trig_prev &&
		(sel_prev == trigger_source_select);
	assign sleep_rise = sleep_i && !sleep_prev;
	// only the rc clock keeps running in sleep
	assign abort = sleep_rise && !dedicated_rc_clock &&
		(state != ST_IDLE);
	assign bit_step = (state == ST_CONV) && (bit_cnt == BIT_LAST);
	assign finish   = bit_step && (idx == '0) && go && !abort;
	assign sw_stop  = (state != ST_IDLE) && !go && !abort;

	// partial result: bits not yet decided repeat the last decided bit
	always_comb begin
		logic last;
		last = 1'b0;
		partial = code;
		if (idx != IDX_TOP) begin
			last = code[idx + 1'b1];
		end
		for (int i = 0; i < RES_W; i++) begin
			if (i <= int'(idx)) begin
				partial[i] = last;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sleep_prev <= 1'b0;
			trig_prev  <= 1'b0;
			sel_prev   <= TRIG_NONE;
		end else begin
			sleep_prev <= sleep_i;
			trig_prev  <= trig_lvl;
			sel_prev   <= trigger_source_select;
		end
	end

	// control register zero and register two
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			converter_enable      <= 1'b0;
			dedicated_rc_clock    <= 1'b0;
			int_enable            <= 1'b0;
			trigger_source_select <= TRIG_NONE;
		end else if (wr_i) begin
			if (addr_i == OFS_CTRL0) begin
				converter_enable   <= wdata_i[BIT_EN];
				dedicated_rc_clock <= wdata_i[BIT_RC];
				int_enable         <= wdata_i[BIT_IE];
			end
			if (addr_i == OFS_CTRL2) begin
				trigger_source_select <= wdata_i[SEL_W-1:0];
			end
		end
	end

	// go bit: hardware trigger set wins over any clear in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			go <= 1'b0;
		end else if (trig_edge && conv_on) begin
			go <= 1'b1;
		end else if (abort || finish) begin
			go <= 1'b0;
		end else if (wr_ctrl0) begin
			go <= wdata_i[BIT_GO] && wdata_i[BIT_EN];
		end else if (!converter_enable) begin
			go <= 1'b0;
		end
	end

	// power-off in sleep; enable bit itself is never touched here
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			power_off <= 1'b0;
		end else if (!sleep_i) begin
			power_off <= 1'b0;
		end else if (sleep_rise && !dedicated_rc_clock) begin
			power_off <= 1'b1;
		end else if (finish && !int_enable) begin
			power_off <= 1'b1;
		end
	end

	// sequencer
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state     <= ST_IDLE;
			delay_cnt <= '0;
			bit_cnt   <= '0;
			idx       <= IDX_TOP;
			code      <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					delay_cnt <= '0;
					bit_cnt   <= '0;
					idx       <= IDX_TOP;
					code      <= {1'b1, {(RES_W-1){1'b0}}};
					if (go && conv_on) begin
						state <= dedicated_rc_clock ? ST_DELAY
							: ST_CONV;
					end
				end
				ST_DELAY: begin
					delay_cnt <= delay_cnt + 1'b1;
					if (abort || sw_stop) begin
						state <= ST_IDLE;
					end else if (delay_cnt == INSTR_LAST) begin
						state <= ST_CONV;
					end
				end
				ST_CONV: begin
					bit_cnt <= bit_step ? '0 : bit_cnt + 1'b1;
					if (abort || sw_stop || finish) begin
						state <= ST_IDLE;
					end else if (bit_step) begin
						code[idx] <= cmp_i;
						if (idx != '0) begin
							code[idx - 1'b1] <= 1'b1;
						end
						idx <= idx - 1'b1;
					end
				end
			endcase
		end
	end

	// result and done flag; hardware set wins over a software clear
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result               <= '0;
			conversion_done_flag <= 1'b0;
		end else begin
			if (finish) begin
				result               <= {code[RES_W-1:1], cmp_i};
				conversion_done_flag <= 1'b1;
			end else begin
				if (sw_stop && state == ST_CONV) begin
					result <= partial;
				end
				if (wr_i && addr_i == OFS_STAT && wdata_i[BIT_DONE]) begin
					conversion_done_flag <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		next_rdata = '0;
		unique case (addr_i)
			OFS_CTRL0: begin
				next_rdata[BIT_EN] = converter_enable;
				next_rdata[BIT_GO] = go;
				next_rdata[BIT_RC] = dedicated_rc_clock;
				next_rdata[BIT_IE] = int_enable;
			end
			OFS_CTRL2: next_rdata[SEL_W-1:0] = trigger_source_select;
			OFS_STAT: begin
				next_rdata[BIT_DONE] = conversion_done_flag;
				next_rdata[BIT_ON]   = conv_on;
				next_rdata[BIT_BUSY] = (state != ST_IDLE);
			end
			OFS_RESH: next_rdata[RESH_W-1:0] = result[RES_W-1:RESL_W];
			OFS_RESL: next_rdata[RESL_W-1:0] = result[RESL_W-1:0];
			default: next_rdata = '0;
		endcase
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rd_i ? next_rdata : '0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trial_code_o   <= '0;
			hold_o         <= 1'b0;
			converter_on_o <= 1'b0;
			wake_o         <= 1'b0;
		end else begin
			trial_code_o   <= code;
			hold_o         <= (state == ST_CONV);
			converter_on_o <= conv_on;
			wake_o         <= finish && sleep_i && int_enable;
		end
	end

endmodule : acs_ctrl

`default_nettype wire

// ===== testbench/acs_ctrl_monitor.sv
// port checker for the converter sleep and auto-trigger control block
// assumes it is bound onto acs_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_mon #(
	parameter int INSTR_CLKS_P = 4,
	parameter int BIT_CLKS_P   = 2
) (
	input wire logic                       clk_i,
	input wire logic                       reset_n_i,
	input wire logic [acs_pkg::ADDR_W-1:0] addr_i,
	input wire logic                       wr_i,
	input wire logic                       rd_i,
	input wire logic [acs_pkg::DATA_W-1:0] rdata_o,
	input wire logic                       sleep_i,
	input wire logic                       hold_o,
	input wire logic                       converter_on_o,
	input wire logic                       wake_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	AST_RDATA_UNMAP: assert property (
		$past(rd_i) && $past(addr_i) > 3'h4 |-> rdata_o == 8'h00)
		else $error("unmapped index read not zero");
	AST_WAKE_ONE: assert property (wake_o |=> !wake_o)
		else $error("wake request longer than one cycle");
	AST_WAKE_ASLEEP: assert property (wake_o |-> sleep_i)
		else $error("wake request while awake");
	AST_WAKE_AT_END: assert property (
		wake_o |-> hold_o ##1 !hold_o)
		else $error("wake request not at conversion end");
	AST_HOLD_ON: assert property (hold_o |-> converter_on_o)
		else $error("converting while powered off");
	AST_OFF_CAUSE: assert property (
		$fell(converter_on_o) |-> sleep_i || $past(wr_i) || $past(wr_i, 2))
		else $error("converter powered off without cause");
	AST_HOLD_BOUND: assert property ($rose(hold_o) |-> ##[1:24] !hold_o)
		else $error("conversion does not finish in time");
	cover property (wake_o);
	cover property ($fell(converter_on_o) && sleep_i);
	cover property ($rose(hold_o));
endmodule : acs_ctrl_mon
bind acs_ctrl acs_ctrl_mon #(
	.INSTR_CLKS_P(INSTR_CLKS_P),
	.BIT_CLKS_P  (BIT_CLKS_P)
) u_mon (.*);
`default_nettype wire

// ===== testbench/acs_ctrl_tb.sv
// self-checking bench for the converter sleep and auto-trigger control
// assumes acs_ctrl at default parameters with its checker bound beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin \
	err_total++; $display("Error %s expected %h seen %h", n, e, s); end end
module adc_sleep_and_auto_trigger_control_tb_top;
	import acs_pkg::*;
	logic        clk_i     = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [2:0]  addr_i    = '0;
	logic [7:0]  wdata_i   = '0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        sleep_i   = 1'b0;
	logic [7:0]  rdata_o;
	logic [7:0]  d;
	logic [9:0]  trial_code_o;
	logic [9:0]  tgt       = '0;
	logic [9:0]  r;
	logic        hold_o;
	logic        converter_on_o;
	logic        wake_o;
	logic [11:0] trig      = '0;
	logic [31:0] seed      = 32'h0000_3566;
	int          err_total = 0;
	int          tests_run = 0;
	int          wakes     = 0;
	int          l0;
	int          l1;
	// ideal comparator: keeps a bit while the trial code is not above target
	wire logic   cmp_i     = (trial_code_o <= tgt);

	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) if (wake_o === 1'b1) wakes++;

	acs_ctrl dut (.*,
		.capture_compare_one_i    (trig[0]),
		.capture_compare_two_i    (trig[1]),
		.timer_zero_wrap_i        (trig[2]),
		.timer_one_wrap_i         (trig[3]),
		.timer_two_period_hit_i   (trig[4]),
		.timer_four_period_hit_i  (trig[5]),
		.timer_six_period_hit_i   (trig[6]),
		.comparator_one_synced_i  (trig[7]),
		.comparator_two_synced_i  (trig[8]),
		.logic_cell_one_output_i  (trig[9]),
		.logic_cell_two_output_i  (trig[10]),
		.logic_cell_three_output_i(trig[11]));

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	// stopped conversion: bits after the n decided ones copy the last one
	function automatic logic [9:0] part(input logic [9:0] t, input int n);
		logic [9:0] p;
		p = t;
		for (int i = 0; i < 10 - n; i++) p[i] = t[10 - n];
		return p;
	endfunction : part
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [2:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		d = rdata_o;
	endtask : bus_rd
	task automatic wrap_up;
		$display("mismatches %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// start by write (tc 0) or by a trigger edge, optionally fall asleep
	task automatic conv(input logic [7:0] c, input logic [3:0] tc,
		input logic s, output int lat);
		tgt <= seed[9:0];
		seed = nxt(seed);
		bus_wr(OFS_STAT, 8'h01);
		if (tc == 0) begin
			bus_wr(OFS_CTRL0, c);
		end else begin
			trig <= seed[11:0] & ~(12'h001 << (tc - 1));
			cyc(2);
			trig <= '0;
			bus_rd(OFS_STAT);
			`CHK("busy", 1'b0, d[BIT_BUSY])
			trig <= 12'h001 << (tc - 1);
		end
		sleep_i <= s;
		for (lat = 0; hold_o !== 1'b1 && lat < 40; lat++) @(posedge clk_i);
		`CHK("start", 1'b1, hold_o)
		if (hold_o !== 1'b1) wrap_up();
		trig <= '0;
		for (int i = 0; i < 30; i++) begin
			bus_rd(OFS_STAT);
			if (d[BIT_DONE] === 1'b1) break;
		end
		`CHK("done", 1'b1, d[BIT_DONE])
		if (d[BIT_DONE] !== 1'b1) wrap_up();
		bus_rd(OFS_RESH);
		r[9:8] = d[1:0];
		bus_rd(OFS_RESL);
		r[7:0] = d;
		`CHK("result", tgt, r)
		bus_rd(OFS_CTRL0);
		`CHK("go", 1'b0, d[BIT_GO])
	endtask : conv

	initial begin
		cyc(5);
		reset_n_i <= 1'b1;
		bus_rd(OFS_CTRL0);
		`CHK("ctrl0 reset", 8'h00, d)
		bus_rd(3'h7);
		`CHK("unmapped", 8'h00, d)
		bus_wr(OFS_CTRL0, 8'h01);
		cyc(2);
		`CHK("on", 1'b1, converter_on_o)
		conv(8'h03, 4'h0, 1'b0, l0);
		conv(8'h07, 4'h0, 1'b0, l1);
		`CHK("rc delay", INSTR_CLKS, l1 - l0)
		bus_wr(OFS_STAT, 8'h01);
		bus_wr(OFS_CTRL0, 8'h03);
		cyc(6);
		sleep_i <= 1'b1;
		cyc(3);
		`CHK("abort on", 1'b0, converter_on_o)
		bus_rd(OFS_CTRL0);
		`CHK("abort ctrl0", 8'h01, d)
		bus_rd(OFS_STAT);
		`CHK("abort done", 1'b0, d[BIT_DONE])
		sleep_i <= 1'b0;
		tgt <= seed[9:0];
		seed = nxt(seed);
		bus_wr(OFS_CTRL0, 8'h03);
		cyc(6);
		// go clear lands after three bit decisions
		bus_wr(OFS_CTRL0, 8'h01);
		bus_rd(OFS_STAT);
		`CHK("stop done", 1'b0, d[BIT_DONE])
		bus_rd(OFS_RESH);
		r[9:8] = d[1:0];
		bus_rd(OFS_RESL);
		r[7:0] = d;
		`CHK("partial", part(tgt, 3), r)
		wakes = 0;
		conv(8'h07, 4'h0, 1'b1, l1);
		`CHK("sleep off", 1'b0, converter_on_o)
		`CHK("no wake", 0, wakes)
		bus_rd(OFS_CTRL0);
		`CHK("sleep ctrl0", 8'h05, d)
		sleep_i <= 1'b0;
		conv(8'h0F, 4'h0, 1'b1, l1);
		`CHK("wake", 1, wakes)
		sleep_i <= 1'b0;
		for (int t = 1; t <= 12; t++) begin
			bus_wr(OFS_CTRL2, t[7:0]);
			conv(8'h00, t[3:0], 1'b0, l1);
		end
		wrap_up();
	end
endmodule : adc_sleep_and_auto_trigger_control_tb_top
`default_nettype wire
